// ==== rtl/frs_pkg.sv ====
// Package of constants, types and helpers for the coprocessor register stack and status word
package frs_pkg;

	// ==========================================================
	// Field layout
	localparam int FRS_NUM_REGS = 8;
	localparam int FRS_EXP_W = 15;
	localparam int FRS_SIG_W = 64;
	localparam int FRS_SW_BUSY = 15;
	localparam int FRS_SW_C3 = 14;
	localparam int FRS_SW_TOP_HI = 13;
	localparam int FRS_SW_TOP_LO = 11;
	localparam int FRS_SW_C2 = 10;
	localparam int FRS_SW_C1 = 9;
	localparam int FRS_SW_C0 = 8;
	localparam int FRS_SW_ES = 7;
	localparam int FRS_SW_SF = 6;
	localparam int FRS_FLAG_INVALID = 0;
	localparam int FRS_FLAG_INEXACT = 5;

	// ==========================================================
	// Tag encodings and reset values
	localparam logic [1:0] FRS_TAG_VALID = 2'h0;
	localparam logic [1:0] FRS_TAG_ZERO = 2'h1;
	localparam logic [1:0] FRS_TAG_SPECIAL = 2'h2;
	localparam logic [1:0] FRS_TAG_EMPTY = 2'h3;
	localparam logic [2:0] FRS_TOP_RESET = 3'h0;
	localparam logic [3:0] FRS_CC_RESET = 4'h0;
	localparam logic [5:0] FRS_FLAGS_RESET = 6'h01;
	localparam logic FRS_ES_RESET = 1'b1;
	localparam logic [FRS_EXP_W-1:0] FRS_EXP_MAX = 15'h7fff;

	// ==========================================================
	// Types
	typedef struct packed {
		logic sign;
		logic [FRS_EXP_W-1:0] exponent;
		logic [FRS_SIG_W-1:0] significand;
	} frs_ext_s;

	typedef enum logic [3:0] {
		FRS_OP_NOP,
		FRS_OP_PUSH,
		FRS_OP_POP,
		FRS_OP_READ,
		FRS_OP_WRITE,
		FRS_OP_COMPARE,
		FRS_OP_CLASSIFY,
		FRS_OP_REMAINDER,
		FRS_OP_ROUND,
		FRS_OP_TRIG,
		FRS_OP_LOAD_STATUS,
		FRS_OP_CLEAR_EXC,
		FRS_OP_INIT
	} frs_op_e;

	typedef enum logic [1:0] {
		FRS_CMP_GT,
		FRS_CMP_LT,
		FRS_CMP_EQ,
		FRS_CMP_UNORD
	} frs_cmp_e;

	typedef struct packed {
		logic valid;
		frs_op_e op;
		logic [2:0] rel_index;
		frs_ext_s data;
		frs_cmp_e cmp;
		logic [2:0] class_code;
		logic [2:0] quotient;
		logic incomplete;
		logic roundup;
		logic [5:0] exceptions;
		logic [15:0] status_image;
	} frs_cmd_s;

	// ==========================================================
	// Helpers
	function automatic logic [2:0] frs_phys(input logic [2:0] top, input logic [2:0] rel);
		frs_phys = top + rel;
	endfunction

	function automatic logic [1:0] frs_tag_of(input frs_ext_s v);
		if (v.exponent == '0 && v.significand == '0) begin
			frs_tag_of = FRS_TAG_ZERO;
		end else if (v.exponent == '0 || v.exponent == FRS_EXP_MAX) begin
			frs_tag_of = FRS_TAG_SPECIAL;
		end else begin
			frs_tag_of = FRS_TAG_VALID;
		end
	endfunction

endpackage

// ==== rtl/frs_core.sv ====
// Register stack, tag word and status word of the floating-point coprocessor
`timescale 1ns/1ps
module frs_core
	import frs_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Operation command
	input wire frs_cmd_s cmd_i,
	input wire logic [5:0] exc_mask_i,
	// Results
	output logic read_valid_o,
	output frs_ext_s read_data_o,
	output logic [15:0] status_word_o,
	output logic [15:0] tag_word_o,
	output logic error_n_o
);

	// ==========================================================
	// State
	typedef struct packed {
		frs_ext_s [FRS_NUM_REGS-1:0] regs;
		logic [FRS_NUM_REGS-1:0][1:0] tags;
		logic [2:0] top;
		logic [3:0] cc;
		logic sf;
		logic [5:0] flags;
		logic es;
		logic rd_valid;
		frs_ext_s rd_data;
	} frs_state_s;

	frs_state_s state;
	frs_state_s next_state;

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [2:0] idx;
		logic [2:0] new_top;
		logic [5:0] raised;
		logic stack_fault;
		logic overflow;
		next_state = state;
		next_state.rd_valid = 1'b0;
		idx = frs_phys(state.top, cmd_i.rel_index);
		new_top = state.top;
		raised = '0;
		stack_fault = 1'b0;
		overflow = 1'b0;
		if (cmd_i.valid) begin
			raised = cmd_i.exceptions;
			unique case (cmd_i.op)
				FRS_OP_NOP: begin
				end
				FRS_OP_PUSH: begin
					new_top = state.top - 3'h1;
					if (state.tags[new_top] != FRS_TAG_EMPTY) begin
						stack_fault = 1'b1;
						overflow = 1'b1;
					end
					next_state.top = new_top;
					next_state.regs[new_top] = cmd_i.data;
					next_state.tags[new_top] = frs_tag_of(cmd_i.data);
				end
				FRS_OP_POP: begin
					if (state.tags[state.top] == FRS_TAG_EMPTY) begin
						stack_fault = 1'b1;
					end
					next_state.rd_valid = 1'b1;
					next_state.rd_data = state.regs[state.top];
					next_state.tags[state.top] = FRS_TAG_EMPTY;
					next_state.top = state.top + 3'h1;
				end
				FRS_OP_READ: begin
					if (state.tags[idx] == FRS_TAG_EMPTY) begin
						stack_fault = 1'b1;
					end
					next_state.rd_valid = 1'b1;
					next_state.rd_data = state.regs[idx];
				end
				FRS_OP_WRITE: begin
					next_state.regs[idx] = cmd_i.data;
					next_state.tags[idx] = frs_tag_of(cmd_i.data);
				end
				FRS_OP_COMPARE: begin
					next_state.cc[1] = 1'b0;
					unique case (cmd_i.cmp)
						FRS_CMP_GT: {next_state.cc[3], next_state.cc[2], next_state.cc[0]} = 3'h0;
						FRS_CMP_LT: {next_state.cc[3], next_state.cc[2], next_state.cc[0]} = 3'h1;
						FRS_CMP_EQ: {next_state.cc[3], next_state.cc[2], next_state.cc[0]} = 3'h4;
						FRS_CMP_UNORD: {next_state.cc[3], next_state.cc[2], next_state.cc[0]} = 3'h7;
					endcase
				end
				FRS_OP_CLASSIFY: begin
					// Empty top overrides the offered class
					next_state.cc[1] = state.regs[state.top].sign;
					if (state.tags[state.top] == FRS_TAG_EMPTY) begin
						{next_state.cc[3], next_state.cc[2], next_state.cc[0]} = 3'h5;
					end else begin
						{next_state.cc[3], next_state.cc[2], next_state.cc[0]} = cmd_i.class_code;
					end
				end
				FRS_OP_REMAINDER: begin
					if (cmd_i.incomplete) begin
						next_state.cc = 4'h4;
					end else begin
						next_state.cc[2] = 1'b0;
						next_state.cc[0] = cmd_i.quotient[2];
						next_state.cc[3] = cmd_i.quotient[1];
						next_state.cc[1] = cmd_i.quotient[0];
					end
					next_state.regs[state.top] = cmd_i.data;
					next_state.tags[state.top] = frs_tag_of(cmd_i.data);
				end
				FRS_OP_ROUND: begin
					if (cmd_i.exceptions[FRS_FLAG_INEXACT]) begin
						next_state.cc[1] = cmd_i.roundup;
					end
					next_state.regs[state.top] = cmd_i.data;
					next_state.tags[state.top] = frs_tag_of(cmd_i.data);
				end
				FRS_OP_TRIG: begin
					next_state.cc[2] = cmd_i.incomplete;
					if (!cmd_i.incomplete) begin
						if (cmd_i.exceptions[FRS_FLAG_INEXACT]) begin
							next_state.cc[1] = cmd_i.roundup;
						end
						next_state.regs[state.top] = cmd_i.data;
						next_state.tags[state.top] = frs_tag_of(cmd_i.data);
					end
				end
				FRS_OP_LOAD_STATUS: begin
					raised = '0;
					next_state.cc[3] = cmd_i.status_image[FRS_SW_C3];
					next_state.cc[2] = cmd_i.status_image[FRS_SW_C2];
					next_state.cc[1] = cmd_i.status_image[FRS_SW_C1];
					next_state.cc[0] = cmd_i.status_image[FRS_SW_C0];
					next_state.top = cmd_i.status_image[FRS_SW_TOP_HI:FRS_SW_TOP_LO];
					next_state.sf = cmd_i.status_image[FRS_SW_SF];
					next_state.flags = cmd_i.status_image[5:0];
				end
				FRS_OP_CLEAR_EXC: begin
					raised = '0;
					next_state.flags = '0;
					next_state.sf = 1'b0;
				end
				FRS_OP_INIT: begin
					raised = '0;
					next_state.flags = '0;
					next_state.sf = 1'b0;
					next_state.cc = FRS_CC_RESET;
					next_state.top = FRS_TOP_RESET;
					for (int i = 0; i < FRS_NUM_REGS; i++) begin
						next_state.tags[i] = FRS_TAG_EMPTY;
					end
				end
				default: begin
				end
			endcase
			// Stack faults are invalid operations with a direction in C1
			if (stack_fault) begin
				raised[FRS_FLAG_INVALID] = 1'b1;
				next_state.sf = 1'b1;
				next_state.cc[1] = overflow;
			end
			next_state.flags = next_state.flags | raised;
		end
		// Summary always follows flags and masks, also after a status load
		next_state.es = |(next_state.flags & ~exc_mask_i);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= '0;
			for (int i = 0; i < FRS_NUM_REGS; i++) begin
				state.tags[i] <= FRS_TAG_EMPTY;
			end
			state.top <= FRS_TOP_RESET;
			state.cc <= FRS_CC_RESET;
			state.flags <= FRS_FLAGS_RESET;
			state.es <= FRS_ES_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		status_word_o = '0;
		status_word_o[FRS_SW_BUSY] = state.es;
		status_word_o[FRS_SW_C3] = state.cc[3];
		status_word_o[FRS_SW_TOP_HI:FRS_SW_TOP_LO] = state.top;
		status_word_o[FRS_SW_C2] = state.cc[2];
		status_word_o[FRS_SW_C1] = state.cc[1];
		status_word_o[FRS_SW_C0] = state.cc[0];
		status_word_o[FRS_SW_ES] = state.es;
		status_word_o[FRS_SW_SF] = state.sf;
		status_word_o[5:0] = state.flags;
	end

	assign tag_word_o = state.tags;
	assign read_valid_o = state.rd_valid;
	assign read_data_o = state.rd_data;
	assign error_n_o = ~state.es;

endmodule

// ==== sim/frs_core_props.sv ====
// Checker properties for the register stack and status word
`timescale 1ns/1ps
module frs_core_props
	import frs_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire frs_cmd_s cmd_i,
	input wire logic [5:0] exc_mask_i,
	input wire logic read_valid_o,
	input wire frs_ext_s read_data_o,
	input wire logic [15:0] status_word_o,
	input wire logic [15:0] tag_word_o,
	input wire logic error_n_o
);
	// ==========================================================
	// Sequences
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	wire logic [2:0] top = status_word_o[13:11];
	wire logic [2:0] ccx = {status_word_o[14], status_word_o[10], status_word_o[8]};
	sequence s_op(frs_op_e o);
		cmd_i.valid && cmd_i.op == o;
	endsequence
	sequence s_full;
		tag_word_o[{top, 1'b0} +: 2] != FRS_TAG_EMPTY;
	endsequence
	// ==========================================================
	// Properties
	AST_MIRROR: assert property (status_word_o[15] == status_word_o[7]) else $error("mirror");
	AST_ERR: assert property (error_n_o == !status_word_o[7]) else $error("error pin");
	AST_PUSH: assert property (s_op(FRS_OP_PUSH) |=> top == $past(top) - 3'h1 ##0 s_full)
		else $error("push");
	AST_POP: assert property (s_op(FRS_OP_POP) |=> read_valid_o && top == $past(top) + 3'h1)
		else $error("pop");
	AST_CMP: assert property (s_op(FRS_OP_COMPARE) ##0 s_full |=>
		ccx == 3'(12'hf08 >> (3 * $past(cmd_i.cmp)))) else $error("compare");
	AST_REM: assert property (s_op(FRS_OP_REMAINDER) ##0 s_full |=> status_word_o[10] == $past(cmd_i.incomplete) &&
		($past(cmd_i.incomplete) || {status_word_o[8], status_word_o[14], status_word_o[9]} == $past(cmd_i.quotient)))
		else $error("remainder");
	AST_TRIG: assert property (s_op(FRS_OP_TRIG) ##0 cmd_i.incomplete |=> status_word_o[10]) else $error("trig");
	AST_LOAD: assert property (s_op(FRS_OP_LOAD_STATUS) |=> status_word_o[14:8] == $past(cmd_i.status_image[14:8]) &&
		status_word_o[7] == |($past(cmd_i.status_image[5:0]) & ~$past(exc_mask_i))) else $error("load");
endmodule

bind frs_core frs_core_props u_props (.clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i), .exc_mask_i(exc_mask_i),
	.read_valid_o(read_valid_o), .read_data_o(read_data_o), .status_word_o(status_word_o),
	.tag_word_o(tag_word_o), .error_n_o(error_n_o));

// ==== sim/frs_host_model.sv ====
// Host model issuing one coprocessor operation per pulse
`timescale 1ns/1ps
module frs_host_model
	import frs_pkg::*;
(
	input wire logic clock_i,
	input wire logic error_n_i,
	output frs_cmd_s cmd_o
);
	// Host-side pointer copies and control bits, kept outside the coprocessor
	frs_op_e saved_op = FRS_OP_NOP;
	logic [2:0] saved_operand = 3'h0;
	logic coproc_absent_bit = 1'b0;
	logic task_switched_bit = 1'b0;
	int vector_16_count = 0;
	int vector_7_count = 0;
	initial cmd_o = '0;
	// Drives on the falling edge, drops valid after one taken edge
	task automatic send(input frs_cmd_s c);
		@(negedge clock_i);
		if (coproc_absent_bit || task_switched_bit) begin
			vector_7_count++;
		end else begin
			// Non-waiting init and clear never trap on a pending error
			if (!error_n_i && c.op != FRS_OP_INIT && c.op != FRS_OP_CLEAR_EXC) begin
				vector_16_count++;
			end
			saved_op = c.op;
			saved_operand = c.rel_index;
			c.valid = 1'b1;
			cmd_o = c;
			@(negedge clock_i);
			cmd_o.valid = 1'b0;
		end
	endtask
endmodule

// ==== sim/fpu_register_stack_status_tb.sv ====
// Self-checking bench for the register stack and status word
`timescale 1ns/1ps
module fpu_register_stack_status_tb
	import frs_pkg::*;
;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [5:0] exc_mask_i = 6'h3e;
	frs_cmd_s cmd_i;
	logic read_valid_o;
	frs_ext_s read_data_o;
	logic [15:0] status_word_o;
	logic [15:0] tag_word_o;
	logic error_n_o;
	int err_total = 0;
	int num_checks = 0;
	logic [31:0] seed = 32'ha144;
	frs_ext_s vals [8];
	frs_cmd_s c;
	logic [2:0] p;
	logic [5:0] e;
	always #2.5 clock_i = ~clock_i;
	frs_host_model host_u (.clock_i(clock_i), .error_n_i(error_n_o), .cmd_o(cmd_i));
	frs_core dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i), .exc_mask_i(exc_mask_i),
		.read_valid_o(read_valid_o), .read_data_o(read_data_o), .status_word_o(status_word_o),
		.tag_word_o(tag_word_o), .error_n_o(error_n_o));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [1:0] exp_tag(input frs_ext_s v);
		if (v.exponent == 15'h0) return (v.significand == 64'h0) ? 2'h1 : 2'h2;
		return (v.exponent == 15'h7fff) ? 2'h2 : 2'h0;
	endfunction
	task automatic chk(input string n, input logic [95:0] x, input logic [95:0] g);
		num_checks++;
		if (g !== x) begin
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
			err_total++;
		end
	endtask
	task automatic op(input frs_op_e o);
		c.op = o;
		host_u.send(c);
	endtask
	task automatic print_verdict;
		if (err_total == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		print_verdict();
	end
	// ==========================================================
	// Scenarios
	initial begin
		c = '0;
		repeat (16) @(negedge clock_i);
		reset_n_i = 1'b1;
		chk("reset sw", 16'h8081, status_word_o);
		chk("reset tags", 16'hffff, tag_word_o);
		op(FRS_OP_CLEAR_EXC);
		chk("clear err", 1'b1, error_n_o);
		for (int i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			if (i < 8) begin
				c.data = (i == 0) ? '0 : {seed[15:0], seed, seed};
				vals[i] = c.data;
			end else c.data = vals[0];
			op(FRS_OP_PUSH);
			p = 3'(7 - i);
			chk("push top", p, status_word_o[13:11]);
			chk("push tag", exp_tag(c.data), tag_word_o[2 * p +: 2]);
		end
		chk("overflow", 5'h1e, {status_word_o[9], status_word_o[6], status_word_o[0], status_word_o[15], error_n_o});
		c.rel_index = 3'h3;
		op(FRS_OP_READ);
		chk("read rel", {read_valid_o, vals[5]}, {1'b1, read_data_o});
		c.rel_index = 3'h0;
		op(FRS_OP_CLEAR_EXC);
		for (int k = 0; k < 8; k++) begin
			p = 3'(7 + k);
			op(FRS_OP_POP);
			chk("pop", {p + 3'h1, vals[3'(7 - p)]}, {status_word_o[13:11], read_data_o});
		end
		op(FRS_OP_POP);
		chk("underflow", 3'h3, {status_word_o[9], status_word_o[6], status_word_o[0]});
		c.data = vals[3];
		op(FRS_OP_PUSH);
		op(FRS_OP_CLEAR_EXC);
		for (int k = 0; k < 4; k++) begin
			c.cmp = frs_cmp_e'(k);
			op(FRS_OP_COMPARE);
			chk("compare", 3'(12'hf08 >> (3 * k)), {status_word_o[14], status_word_o[10], status_word_o[8]});
		end
		for (int k = 0; k < 7; k++) begin
			c.class_code = 3'(k);
			op(FRS_OP_CLASSIFY);
			chk("classify", {vals[3].sign, 3'(k)}, {status_word_o[9], status_word_o[14], status_word_o[10], status_word_o[8]});
		end
		c.data = vals[1];
		for (int k = 0; k < 8; k++) begin
			c.quotient = 3'(k);
			op(FRS_OP_REMAINDER);
			chk("quotient", k, {status_word_o[10], status_word_o[8], status_word_o[14], status_word_o[9]});
		end
		c.incomplete = 1'b1;
		op(FRS_OP_REMAINDER);
		chk("rem part", 4'h4, {status_word_o[14], status_word_o[10:8]});
		c.data = vals[2];
		op(FRS_OP_TRIG);
		op(FRS_OP_READ);
		chk("trig kept", {1'b1, vals[1]}, {status_word_o[10], read_data_o});
		c.incomplete = 1'b0;
		c.roundup = 1'b1;
		c.exceptions = 6'h20;
		exc_mask_i = 6'h1f;
		op(FRS_OP_ROUND);
		chk("roundup", 4'he, {status_word_o[9], status_word_o[5], status_word_o[7], error_n_o});
		exc_mask_i = 6'h3f;
		@(negedge clock_i);
		chk("masked", 2'h1, {status_word_o[7], error_n_o});
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			c.status_image = seed[15:0];
			exc_mask_i = seed[21:16];
			op(FRS_OP_LOAD_STATUS);
			e = seed[5:0] & ~seed[21:16];
			chk("load", {|e, seed[14:8], |e, seed[6:0], !(|e)}, {status_word_o, error_n_o});
		end
		c.exceptions = 6'h00;
		exc_mask_i = 6'h3e;
		op(FRS_OP_INIT);
		chk("init", 33'h1ffff, {status_word_o, tag_word_o, error_n_o});
		c.class_code = 3'h2;
		op(FRS_OP_CLASSIFY);
		chk("classify empty", {vals[7].sign, 3'h5}, {status_word_o[9], status_word_o[14], status_word_o[10], status_word_o[8]});
		c.rel_index = 3'h5;
		c.data = vals[6];
		op(FRS_OP_WRITE);
		op(FRS_OP_READ);
		chk("write rel", {1'b1, exp_tag(vals[6]), vals[6]}, {read_valid_o, tag_word_o[11:10], read_data_o});
		c.rel_index = 3'h0;
		reset_n_i = 1'b0;
		@(negedge clock_i);
		reset_n_i = 1'b1;
		chk("reset again", {16'h8081, 16'hffff, 1'b0, 1'b0}, {status_word_o, tag_word_o, error_n_o, read_valid_o});
		print_verdict();
	end
endmodule
